/* rtl/dcf_channel.sv */
// Contract
// - Flag when dest pointer reaches half size
// - Flag block done or pattern match
// - Flag each completed cell of bytes
// - Matching abort request stops transfer, flags
// - Flag invalid source or destination address
// - Source size field sixteen bits wide
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dcf_params.svh"
module dcf_channel #(
  parameter int SIZE_W = `DCF_SIZE_W,
  parameter int IRQ_W = `DCF_IRQ_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DCF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transfer engine side
  input wire logic beat,
  input wire logic pattern_match,
  input wire logic irq_valid,
  input wire logic [IRQ_W-1:0] irq_num,
  input wire logic src_addr_bad,
  input wire logic dst_addr_bad,
  // Channel state
  output logic busy,
  output logic [31:0] cur_src_addr,
  output logic [31:0] cur_dst_addr
);
  // ********************
  // Elaboration checks
  // ********************
  if (SIZE_W < 2 || SIZE_W > 16) begin : g_bad_size
    $error("SIZE_W must lie in 2..16");
  end
  if (IRQ_W < 1 || IRQ_W > 8) begin : g_bad_irq
    $error("IRQ_W must lie in 1..8");
  end

  // ********************
  // Functions
  // ********************
  function automatic logic [SIZE_W-1:0] inc_wrap(input logic [SIZE_W-1:0] p, input logic [SIZE_W-1:0] sz);
    logic [SIZE_W:0] t;
    t = {1'b0, p} + {{SIZE_W{1'b0}}, 1'b1};
    inc_wrap = (t >= {1'b0, sz}) ? '0 : t[SIZE_W-1:0];
  endfunction

  function automatic logic [31:0] zext(input logic [SIZE_W-1:0] v);
    logic [31:0] r;
    r = '0;
    r[SIZE_W-1:0] = v;
    zext = r;
  endfunction

  // ********************
  // State
  // ********************
  dcf_pkg::dcf_state_t state_ff, nxt_state;
  logic [31:0] ssa_ff, nxt_ssa, dsa_ff, nxt_dsa;
  logic [SIZE_W-1:0] ssiz_ff, nxt_ssiz, dsiz_ff, nxt_dsiz, csiz_ff, nxt_csiz;
  logic [SIZE_W-1:0] sptr_ff, nxt_sptr, dptr_ff, nxt_dptr, cell_ff, nxt_cell, moved_ff, nxt_moved;
  logic aen_ff, nxt_aen;
  logic [IRQ_W-1:0] airq_ff, nxt_airq;
  logic [31:0] prdata_ff, nxt_prdata, csrc_ff, nxt_csrc, cdst_ff, nxt_cdst;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic [`DCF_NFLAGS-1:0] set_vec, clr_vec, flags;
  logic acc, wr, rd, hit, beat_ok, abort_hit, err_hit, stop, blk_done;
  logic [SIZE_W-1:0] big, dptr_inc;

  // ********************
  // Bus decode and engine
  // ********************
  always_comb begin
    // Writes commit on the edge that samples pready high; reads latch prdata one edge earlier, as pready rises
    acc = psel && penable && !pready_ff;
    wr = psel && penable && pready_ff && pwrite;
    rd = acc && !pwrite;
    hit = 1'b1;
    nxt_prdata = prdata_ff;
    nxt_pready = acc;
    nxt_ssa = ssa_ff;
    nxt_dsa = dsa_ff;
    nxt_ssiz = ssiz_ff;
    nxt_dsiz = dsiz_ff;
    nxt_csiz = csiz_ff;
    nxt_aen = aen_ff;
    nxt_airq = airq_ff;
    clr_vec = '0;
    nxt_state = state_ff;
    nxt_sptr = sptr_ff;
    nxt_dptr = dptr_ff;
    nxt_cell = cell_ff;
    nxt_moved = moved_ff;
    set_vec = '0;
    case (paddr)
      `DCF_OFF_INT: begin
        if (rd) begin
          nxt_prdata = `DCF_RST_WORD;
          nxt_prdata[`DCF_NFLAGS-1:0] = flags;
        end
        if (wr) clr_vec = pwdata[`DCF_NFLAGS-1:0];
      end
      `DCF_OFF_SSA: begin
        if (rd) nxt_prdata = ssa_ff;
        if (wr) nxt_ssa = pwdata;
      end
      `DCF_OFF_DSA: begin
        if (rd) nxt_prdata = dsa_ff;
        if (wr) nxt_dsa = pwdata;
      end
      `DCF_OFF_SSIZ: begin
        if (rd) nxt_prdata = zext(ssiz_ff);
        if (wr) nxt_ssiz = pwdata[SIZE_W-1:0];
      end
      `DCF_OFF_DSIZ: begin
        if (rd) nxt_prdata = zext(dsiz_ff);
        if (wr) nxt_dsiz = pwdata[SIZE_W-1:0];
      end
      `DCF_OFF_CSIZ: begin
        if (rd) nxt_prdata = zext(csiz_ff);
        if (wr) nxt_csiz = pwdata[SIZE_W-1:0];
      end
      `DCF_OFF_CTRL: begin
        if (rd) begin
          nxt_prdata = `DCF_RST_WORD;
          nxt_prdata[`DCF_CTRL_EN] = (state_ff == dcf_pkg::DCF_BUSY);
          nxt_prdata[`DCF_CTRL_AEN] = aen_ff;
          nxt_prdata[`DCF_CTRL_IRQ_LSB +: IRQ_W] = airq_ff;
        end
        if (wr) begin
          nxt_aen = pwdata[`DCF_CTRL_AEN];
          nxt_airq = pwdata[`DCF_CTRL_IRQ_LSB +: IRQ_W];
        end
      end
      `DCF_OFF_PTR: begin
        if (rd) nxt_prdata = zext(sptr_ff) | (zext(dptr_ff) << `DCF_PTR_DST_LSB);
      end
      default: begin
        hit = 1'b0;
        if (rd) nxt_prdata = `DCF_RST_WORD;
      end
    endcase
    nxt_pslverr = acc && !hit;

    big = (ssiz_ff > dsiz_ff) ? ssiz_ff : dsiz_ff;
    dptr_inc = inc_wrap(dptr_ff, dsiz_ff);
    beat_ok = (state_ff == dcf_pkg::DCF_BUSY) && beat;
    abort_hit = (state_ff == dcf_pkg::DCF_BUSY) && aen_ff && irq_valid && (irq_num == airq_ff);
    err_hit = (state_ff == dcf_pkg::DCF_BUSY) && (src_addr_bad || dst_addr_bad);
    // An abort or error swallows the beat of the same cycle
    stop = abort_hit || err_hit;
    blk_done = !stop && ((beat_ok && ({1'b0, moved_ff} + 1'b1 == {1'b0, big})) ||
                         ((state_ff == dcf_pkg::DCF_BUSY) && pattern_match));
    set_vec[`DCF_FLAG_TA] = abort_hit;
    set_vec[`DCF_FLAG_ER] = err_hit;
    set_vec[`DCF_FLAG_BC] = blk_done;

    case (state_ff)
      dcf_pkg::DCF_IDLE: begin
        if (wr && paddr == `DCF_OFF_CTRL && pwdata[`DCF_CTRL_EN]) begin
          nxt_state = dcf_pkg::DCF_BUSY;
          nxt_sptr = '0;
          nxt_dptr = '0;
          nxt_cell = '0;
          nxt_moved = '0;
        end
      end
      dcf_pkg::DCF_BUSY: begin
        if (beat_ok && !stop) begin
          nxt_sptr = inc_wrap(sptr_ff, ssiz_ff);
          nxt_dptr = dptr_inc;
          nxt_cell = inc_wrap(cell_ff, csiz_ff);
          nxt_moved = moved_ff + 1'b1;
          set_vec[`DCF_FLAG_DHF] = (dsiz_ff >> 1) != '0 && dptr_inc == (dsiz_ff >> 1);
          set_vec[`DCF_FLAG_CC] = (nxt_cell == '0);
        end
        if (stop || blk_done || (wr && paddr == `DCF_OFF_CTRL && !pwdata[`DCF_CTRL_EN])) begin
          nxt_state = dcf_pkg::DCF_IDLE;
        end
      end
      default: nxt_state = dcf_pkg::DCF_IDLE;
    endcase
    nxt_csrc = nxt_ssa + zext(nxt_sptr);
    nxt_cdst = nxt_dsa + zext(nxt_dptr);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_ff <= dcf_pkg::DCF_IDLE;
      ssa_ff <= `DCF_RST_WORD;
      dsa_ff <= `DCF_RST_WORD;
      ssiz_ff <= '0;
      dsiz_ff <= '0;
      csiz_ff <= '0;
      aen_ff <= 1'b0;
      airq_ff <= '0;
      sptr_ff <= '0;
      dptr_ff <= '0;
      cell_ff <= '0;
      moved_ff <= '0;
      prdata_ff <= `DCF_RST_WORD;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      csrc_ff <= `DCF_RST_WORD;
      cdst_ff <= `DCF_RST_WORD;
    end else begin
      state_ff <= nxt_state;
      ssa_ff <= nxt_ssa;
      dsa_ff <= nxt_dsa;
      ssiz_ff <= nxt_ssiz;
      dsiz_ff <= nxt_dsiz;
      csiz_ff <= nxt_csiz;
      aen_ff <= nxt_aen;
      airq_ff <= nxt_airq;
      sptr_ff <= nxt_sptr;
      dptr_ff <= nxt_dptr;
      cell_ff <= nxt_cell;
      moved_ff <= nxt_moved;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      csrc_ff <= nxt_csrc;
      cdst_ff <= nxt_cdst;
    end
  end

  dcf_flag_unit #(.W(`DCF_NFLAGS)) u_flags (
    .mclk(mclk),
    .rstn(rstn),
    .set_vec(set_vec),
    .clr_vec(clr_vec),
    .flags(flags)
  );

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign busy = (state_ff == dcf_pkg::DCF_BUSY);
  assign cur_src_addr = csrc_ff;
  assign cur_dst_addr = cdst_ff;

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_half_full_set: assert property (
    beat_ok && !stop && dptr_inc == (dsiz_ff >> 1) && (dsiz_ff >> 1) != '0 |=> flags[`DCF_FLAG_DHF])
    else $error("half full flag missed");
  a_block_done_idle: assert property (blk_done |=> flags[`DCF_FLAG_BC] && !busy) else $error("block done missed");
  a_cell_flag_set: assert property (
    beat_ok && !stop && inc_wrap(cell_ff, csiz_ff) == '0 |=> flags[`DCF_FLAG_CC])
    else $error("cell flag missed");
  a_abort_stops_xfer: assert property (
    abort_hit |=> !busy && flags[`DCF_FLAG_TA] && $stable(dptr_ff))
    else $error("abort not taken");
  a_addr_error_set: assert property (err_hit |=> flags[`DCF_FLAG_ER] && !busy)
    else $error("address error missed");
  a_src_size_store: assert property (wr && paddr == `DCF_OFF_SSIZ |=> ssiz_ff == $past(pwdata[SIZE_W-1:0]))
    else $error("source size not stored");
  a_flag_sticky: assert property (
    1'b1 |=> (flags & $past(flags) & ~$past(clr_vec)) == ($past(flags) & ~$past(clr_vec)))
    else $error("flag dropped without clear");
  a_apb_one_wait: assert property (acc |=> pready_ff ##1 !pready_ff) else $error("apb ready timing wrong");

  c_block_done: cover property (blk_done);
  c_abort: cover property (abort_hit);
  c_half_then_block: cover property (set_vec[`DCF_FLAG_DHF] ##[1:64] blk_done);
endmodule
`default_nettype wire

/* rtl/dcf_flag_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module dcf_flag_unit #(
  parameter int W = 5
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Events and clears
  input wire logic [W-1:0] set_vec,
  input wire logic [W-1:0] clr_vec,
  // Sticky flags
  output logic [W-1:0] flags
);
  if (W < 1) begin : g_bad_width
    $error("W must be at least 1");
  end

  logic [W-1:0] flags_ff;
  logic [W-1:0] nxt_flags;

  always_comb begin
    nxt_flags = (flags_ff & ~clr_vec) | set_vec;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;
endmodule
`default_nettype wire

/* rtl/dcf_params.svh */
`ifndef DCF_PARAMS_SVH
`define DCF_PARAMS_SVH
// ********************
// Register offsets
// ********************
`define DCF_OFF_INT 8'h00
`define DCF_OFF_SSA 8'h10
`define DCF_OFF_DSA 8'h20
`define DCF_OFF_SSIZ 8'h30
`define DCF_OFF_DSIZ 8'h40
`define DCF_OFF_CSIZ 8'h50
`define DCF_OFF_CTRL 8'h60
`define DCF_OFF_PTR 8'h70
// ********************
// Field positions
// ********************
`define DCF_NFLAGS 5
`define DCF_FLAG_DHF 4
`define DCF_FLAG_BC 3
`define DCF_FLAG_CC 2
`define DCF_FLAG_TA 1
`define DCF_FLAG_ER 0
`define DCF_CTRL_EN 0
`define DCF_CTRL_AEN 1
`define DCF_CTRL_IRQ_LSB 8
`define DCF_PTR_DST_LSB 16
// ********************
// Reset values and widths
// ********************
`define DCF_RST_WORD 32'h00000000
`define DCF_SIZE_W 16
`define DCF_IRQ_W 8
`define DCF_ADDR_W 8
`endif

/* rtl/dcf_pkg.sv */
package dcf_pkg;
  typedef enum logic [0:0] {
    DCF_IDLE = 1'b0,
    DCF_BUSY = 1'b1
  } dcf_state_t;
endpackage

/* tb/dcf_channel_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dcf_params.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("FAIL %s exp %h got %h", nm, e, g); end end
// ****************************
// Channel bench
// ****************************
module dcf_channel_tb_top;
  logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00, num = 8'h00, irq_num;
  logic [31:0] pwdata = 32'h00000000, prdata, rd, cur_src_addr, cur_dst_addr, wv[3];
  logic [3:0] ev = 4'h0;
  logic pready, pslverr, busy, beat, pattern_match, irq_valid, src_addr_bad, dst_addr_bad, er;
  int err_count = 0, num_checks = 0, cyc = 0, seed = 32'hBE5E, s, d, c;

  always #4 mclk = ~mclk;

  dcf_channel u_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .beat(beat),
    .pattern_match(pattern_match), .irq_valid(irq_valid), .irq_num(irq_num), .src_addr_bad(src_addr_bad),
    .dst_addr_bad(dst_addr_bad), .busy(busy), .cur_src_addr(cur_src_addr), .cur_dst_addr(cur_dst_addr));
  dcf_engine_model u_eng (.mclk(mclk), .rstn(rstn), .busy(busy), .go(go), .slow(slow), .ev(ev), .num(num),
    .beat(beat), .pattern_match(pattern_match), .irq_valid(irq_valid), .irq_num(irq_num),
    .src_addr_bad(src_addr_bad), .dst_addr_bad(dst_addr_bad));

  task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge mclk);
    penable <= 1'b1;
    // No bound of its own: the wait ends on ready or at the cycle ceiling
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_idle;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (busy !== 1'b0 && n < 300);
  endtask

  task evt(input logic [3:0] e, input logic [7:0] nb);
    @(posedge mclk);
    ev <= e;
    num <= nb;
    @(posedge mclk);
    ev <= 4'h0;
    repeat (3) @(posedge mclk);
  endtask

  function logic [31:0] exp_int(int s, int d, int c);
    return {27'h0, d >= 2, 1'b1, c <= (s > d ? s : d), 2'b00};
  endfunction

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run;
    end
  end

  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(i * 16), 32'h0);
      `CHK("reset", 32'h0, rd)
    end
    for (int i = 1; i < 3; i++) begin
      wv[i] = $random(seed);
      apb(1'b1, 8'(i * 16), wv[i]);
      apb(1'b0, 8'(i * 16), 32'h0);
      `CHK("start addr", wv[i], rd)
    end
    apb(1'b1, `DCF_OFF_SSIZ, 32'hFFFFFFFF);
    apb(1'b0, `DCF_OFF_SSIZ, 32'h0);
    `CHK("src size", 32'h0000FFFF, rd)
    apb(1'b0, 8'h80, 32'h0);
    `CHK("unmapped", 33'h100000000, {er, rd})
    $display("test registers done");
    // First pass is the hand-checked short block
    for (int i = 0; i < 6; i++) begin
      s = (i == 0) ? 4 : 1 + ($random(seed) & 15);
      d = (i == 0) ? 4 : 1 + ($random(seed) & 15);
      c = (i == 0) ? 2 : 1 + ($random(seed) & 7);
      apb(1'b1, `DCF_OFF_SSIZ, 32'(s));
      apb(1'b1, `DCF_OFF_DSIZ, 32'(d));
      apb(1'b1, `DCF_OFF_CSIZ, 32'(c));
      slow <= 1'($random(seed));
      go <= 1'b1;
      apb(1'b1, `DCF_OFF_CTRL, 32'h1);
      wait_idle;
      `CHK("done", 1'b0, busy)
      go <= 1'b0;
      apb(1'b0, `DCF_OFF_INT, 32'h0);
      `CHK("flags", exp_int(s, d, c), rd)
      apb(1'b0, `DCF_OFF_INT, 32'h0);
      `CHK("sticky", exp_int(s, d, c), rd)
      apb(1'b1, `DCF_OFF_INT, 32'h1F);
      apb(1'b0, `DCF_OFF_INT, 32'h0);
      `CHK("clear", 32'h0, rd)
    end
    $display("test transfers done");
    // No beats here, so only the event flag can appear
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `DCF_OFF_CTRL, 32'h00005A03);
      evt(4'h2, 8'h5B);
      `CHK("busy", 1'b1, busy)
      `CHK("cur src", wv[1], cur_src_addr)
      `CHK("cur dst", wv[2], cur_dst_addr)
      evt(4'(1 << i), 8'h5A);
      wait_idle;
      `CHK("idle", 1'b0, busy)
      apb(1'b0, `DCF_OFF_INT, 32'h0);
      `CHK("event", 32'(i == 0 ? 8 : i == 1 ? 2 : 1), rd)
      apb(1'b1, `DCF_OFF_INT, 32'h1F);
    end
    evt(4'hF, 8'h5A);
    apb(1'b0, `DCF_OFF_INT, 32'h0);
    `CHK("idle events", 32'h0, rd)
    apb(1'b1, `DCF_OFF_CTRL, 32'h1);
    apb(1'b0, `DCF_OFF_CTRL, 32'h0);
    `CHK("ctrl", 32'h00000001, rd)
    apb(1'b1, `DCF_OFF_CTRL, 32'h0);
    @(posedge mclk);
    `CHK("stopped", 1'b0, busy)
    $display("test events done");
    complete_run;
  end
endmodule
`default_nettype wire

/* tb/dcf_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************
// Transfer engine model
// ****************************
module dcf_engine_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Bench control
  input wire logic busy,
  input wire logic go,
  input wire logic slow,
  input wire logic [3:0] ev,
  input wire logic [7:0] num,
  // Engine outputs
  output logic beat,
  output logic pattern_match,
  output logic irq_valid,
  output logic [7:0] irq_num,
  output logic src_addr_bad,
  output logic dst_addr_bad
);
  // Slow mode skips every other beat to stall the channel
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      {beat, dst_addr_bad, src_addr_bad, irq_valid, pattern_match} <= 5'h00;
      irq_num <= 8'h00;
    end else begin
      beat <= busy & go & (~slow | ~beat);
      {dst_addr_bad, src_addr_bad, irq_valid, pattern_match} <= ev;
      // Number toggles when not presented, never a stale match
      irq_num <= ev[1] ? num : ~irq_num;
    end
  end
endmodule
`default_nettype wire
